// ===== logic/hk_cmd_pkg.sv
// Constants, types and register map of the housekeeping command executor.
// Operation
// - Both power-query command codes are accepted and handled the same way.
// - Power query loads all ones when spun up and awake, else zero.
// - Self-diagnostic runs internal tests and puts the outcome in the error register.
// - After self-diagnostic the error register holds a result code, not flags.
// - Cache flush writes every pending write-cache entry to the media.
// - Flush completion is reported only after all cache entries are committed.
// - Track format formats exactly one track chosen by the address registers.
// - Track format writes zeros into every good sector of the track.
// - Track format never reads back or verifies the zeroed sectors.
// - A format table sent by the host is discarded; zeros are still written.
// - Every track is laid out the same, 1:1 interleave, whatever numbering requested.
// - Logical-mode format completion reports the current address in result registers.
// - Addressing-select bit: zero cylinder-head-sector, one logical-block.
// - Device-select bit: zero master, one slave.
// - Out-of-range logical address aborts format and sets the aborted flag.
// - Logical-mode format works on the track holding the supplied address.
package hk_cmd_pkg;

  localparam logic [11:0] ADDR_SECTOR_COUNT = 12'h008;
  localparam logic [11:0] ADDR_SECTOR_NUMBER = 12'h00C;
  localparam logic [11:0] ADDR_CYL_LOW = 12'h010;
  localparam logic [11:0] ADDR_CYL_HIGH = 12'h014;
  localparam logic [11:0] ADDR_DEV_HEAD = 12'h018;
  localparam logic [11:0] ADDR_COMMAND = 12'h01C;
  localparam logic [11:0] ADDR_ERROR = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  localparam logic [11:0] ADDR_CONTROL = 12'h024;

  localparam logic [7:0] CMD_POWER_QUERY = 8'hE5;
  localparam logic [7:0] CMD_POWER_QUERY_ALT = 8'h98;
  localparam logic [7:0] CMD_DIAGNOSE = 8'h90;
  localparam logic [7:0] CMD_FLUSH = 8'hE7;
  localparam logic [7:0] CMD_FORMAT_TRACK = 8'h50;

  localparam logic [7:0] POWER_ACTIVE = 8'hFF;
  localparam logic [7:0] POWER_IDLE = 8'h00;
  localparam int SPT = 63;
  localparam logic [27:0] SECTORS_PER_TRACK = 28'h000003F;
  localparam int HEAD_COUNT = 16;
  localparam logic [27:0] HEADS_PER_CYL = 28'h0000010;
  localparam int LBA_W = 28;

  localparam int BIT_LBA_MODE = 6;
  localparam int BIT_DEV_SELECT = 4;
  localparam int BIT_ABORT = 2;
  localparam int BIT_IDNF = 4;
  localparam int BIT_BUSY = 7;
  localparam int BIT_READY = 6;
  localparam int BIT_FAULT = 5;
  localparam int BIT_SEEK_DONE = 4;
  localparam int BIT_ERROR = 0;
  localparam int BIT_CTL_DEVICE_ID = 0;
  localparam logic [7:0] ERR_NONE = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DIAG = 6'b000010,
    ST_FLUSH = 6'b000100,
    ST_FMT_SEEK = 6'b001000,
    ST_FMT_WRITE = 6'b010000,
    ST_DONE = 6'b100000
  } state_type;

  // Parameter block written by the host.
  typedef struct packed {
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
  } taskfile_type;

  // Request to the media/sector engine.
  typedef struct packed {
    logic write_zero;
    logic flush;
    logic diag;
    logic [27:0] lba;
  } media_req_type;

endpackage

// ===== logic/hk_cmd_exec.sv
// Housekeeping command executor with an APB register block.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hk_cmd_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spindle_at_speed,
  input wire logic standby_mode,
  input wire logic sleep_mode,
  input wire logic [27:0] max_lba,
  output hk_cmd_pkg::media_req_type media_req,
  output logic media_req_valid,
  input wire logic media_ack,
  input wire logic media_sector_bad,
  input wire logic cache_dirty,
  input wire logic [7:0] diag_code
);
  import hk_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  state_type state, next_state;
  taskfile_type tf, next_tf;
  logic [7:0] cmd, next_cmd;
  logic [7:0] err, next_err;
  logic status_err, next_status_err;
  logic [27:0] lba, next_lba;
  logic [5:0] sect, next_sect;
  logic device_id, next_device_id;
  logic wr, rd, busy, selected, lba_mode;
  logic [27:0] chs_lba, host_lba, track_base;
  logic [7:0] cmd_in;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign busy = (state != ST_IDLE);
  assign lba_mode = tf.dev_head[BIT_LBA_MODE];
  assign selected = (tf.dev_head[BIT_DEV_SELECT] == device_id);
  assign cmd_in = pwdata[7:0];

  // Address of the target track in either mode.
  assign host_lba = {tf.dev_head[3:0], tf.cyl_high, tf.cyl_low, tf.sector_number};
  assign chs_lba = 28'(({12'h000, tf.cyl_high, tf.cyl_low} * HEADS_PER_CYL
                   + {24'h000000, tf.dev_head[3:0]}) * SECTORS_PER_TRACK);
  assign track_base = lba_mode ? 28'(host_lba - (host_lba % SECTORS_PER_TRACK))
                               : chs_lba;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_tf = tf;
    next_cmd = cmd;
    next_err = err;
    next_status_err = status_err;
    next_lba = lba;
    next_sect = sect;
    next_device_id = device_id;
    // Parameter writes are ignored while a command runs.
    if (wr && !busy)
    begin
      case (paddr)
        ADDR_SECTOR_COUNT: next_tf.sector_count = pwdata[7:0];
        ADDR_SECTOR_NUMBER: next_tf.sector_number = pwdata[7:0];
        ADDR_CYL_LOW: next_tf.cyl_low = pwdata[7:0];
        ADDR_CYL_HIGH: next_tf.cyl_high = pwdata[7:0];
        ADDR_DEV_HEAD: next_tf.dev_head = pwdata[7:0];
        ADDR_CONTROL: next_device_id = pwdata[BIT_CTL_DEVICE_ID];
        default: ;
      endcase
    end
    case (state)
      ST_IDLE:
      begin
        if (wr && paddr == ADDR_COMMAND && (selected || cmd_in == CMD_DIAGNOSE))
        begin
          next_cmd = cmd_in;
          next_err = ERR_NONE;
          next_status_err = 1'b0;
          case (cmd_in)
            CMD_POWER_QUERY, CMD_POWER_QUERY_ALT:
            begin
              next_tf.sector_count = (spindle_at_speed && !standby_mode && !sleep_mode)
                                     ? POWER_ACTIVE : POWER_IDLE;
              next_state = ST_DONE;
            end
            CMD_DIAGNOSE: next_state = ST_DIAG;
            CMD_FLUSH: next_state = ST_FLUSH;
            CMD_FORMAT_TRACK:
            begin
              // A format table written as data is never consumed.
              if (lba_mode && host_lba > max_lba)
              begin
                next_err[BIT_ABORT] = 1'b1;
                next_status_err = 1'b1;
                next_state = ST_DONE;
              end
              else
              begin
                next_state = ST_FMT_SEEK;
              end
            end
            default:
            begin
              next_err[BIT_ABORT] = 1'b1;
              next_status_err = 1'b1;
              next_state = ST_DONE;
            end
          endcase
        end
      end
      ST_DIAG:
        if (media_ack)
        begin
          next_err = diag_code;
          next_state = ST_DONE;
        end
      ST_FLUSH:
        if (media_ack && !cache_dirty)
          next_state = ST_DONE;
      ST_FMT_WRITE:
        if (media_ack)
        begin
          // Sectors are written in ascending order, 1:1, with no read-back.
          if (sect == 6'(SPT - 1))
          begin
            if (lba_mode)
            begin
              next_tf.sector_number = lba[7:0];
              next_tf.cyl_low = lba[15:8];
              next_tf.cyl_high = lba[23:16];
              next_tf.dev_head[3:0] = lba[27:24];
            end
            next_state = ST_DONE;
          end
          else
          begin
            next_sect = 6'(sect + 6'h01);
            next_lba = 28'(lba + 28'h0000001);
          end
        end
      ST_FMT_SEEK:
      begin
        // Parameter writes are locked out while busy, so the track address is steady here.
        next_lba = track_base;
        next_sect = 6'h00;
        next_state = ST_FMT_WRITE;
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      tf <= '0;
      cmd <= 8'h00;
      err <= 8'h00;
      status_err <= 1'b0;
      lba <= 28'h0000000;
      sect <= 6'h00;
      device_id <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tf <= next_tf;
      cmd <= next_cmd;
      err <= next_err;
      status_err <= next_status_err;
      lba <= next_lba;
      sect <= next_sect;
      device_id <= next_device_id;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Media requests; a bad sector is skipped by the engine and simply acked.
  always_comb
  begin
    media_req = '0;
    media_req.lba = lba;
    media_req.diag = (state == ST_DIAG);
    media_req.flush = (state == ST_FLUSH);
    media_req.write_zero = (state == ST_FMT_WRITE) && !media_sector_bad;
    media_req_valid = (state == ST_DIAG) || (state == ST_FLUSH) || (state == ST_FMT_WRITE);
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] status_byte;
  logic [31:0] next_prdata;
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[BIT_BUSY] = busy;
    status_byte[BIT_READY] = !busy;
    status_byte[BIT_SEEK_DONE] = !busy;
    status_byte[BIT_ERROR] = status_err && !busy;
    next_prdata = prdata;
    if (rd)
    begin
      case (paddr)
        ADDR_ERROR: next_prdata = {24'h000000, busy ? 8'h00 : err};
        ADDR_SECTOR_COUNT: next_prdata = {24'h000000, tf.sector_count};
        ADDR_SECTOR_NUMBER: next_prdata = {24'h000000, tf.sector_number};
        ADDR_CYL_LOW: next_prdata = {24'h000000, tf.cyl_low};
        ADDR_CYL_HIGH: next_prdata = {24'h000000, tf.cyl_high};
        ADDR_DEV_HEAD: next_prdata = {24'h000000, tf.dev_head};
        ADDR_COMMAND: next_prdata = {24'h000000, cmd};
        ADDR_STATUS: next_prdata = {24'h000000, status_byte};
        ADDR_CONTROL: next_prdata = {31'h00000000, device_id};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else
      prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; an access outside the register map answers with an error.
  logic mapped;
  always_comb
  begin
    case (paddr)
      ADDR_ERROR,
      ADDR_SECTOR_COUNT,
      ADDR_SECTOR_NUMBER,
      ADDR_CYL_LOW,
      ADDR_CYL_HIGH,
      ADDR_DEV_HEAD,
      ADDR_COMMAND,
      ADDR_STATUS,
      ADDR_CONTROL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule // hk_cmd_exec
`default_nettype wire

// ===== bench/hk_cmd_chk.sv
// Port assertions for the housekeeping command executor.
`timescale 1ns/1ps
`default_nettype none
module hk_cmd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire hk_cmd_pkg::media_req_type media_req,
  input wire logic media_req_valid,
  input wire logic media_ack,
  input wire logic cache_dirty
);
  import hk_cmd_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cmd_w;
  logic st_rd;
  assign cmd_w = psel && penable && pwrite && paddr == ADDR_COMMAND && !media_req_valid;
  assign st_rd = psel && !penable && !pwrite && paddr == ADDR_STATUS;
  diag_start_a: assert property (
    cmd_w && pwdata[7:0] == CMD_DIAGNOSE |-> ##[1:3] media_req_valid && media_req.diag)
    else $error("diagnostic request missing");
  flush_start_a: assert property (
    cmd_w && pwdata[7:0] == CMD_FLUSH |-> ##[1:3] media_req_valid && media_req.flush)
    else $error("flush request missing");
  query_no_media_a: assert property (
    cmd_w && (pwdata[7:0] == CMD_POWER_QUERY || pwdata[7:0] == CMD_POWER_QUERY_ALT)
    |=> !media_req_valid [*2])
    else $error("power query touched the media");
  flush_commit_a: assert property (
    media_req_valid && media_req.flush && cache_dirty && media_ack
    |=> media_req_valid && media_req.flush)
    else $error("flush ended with dirty cache");
  req_hold_a: assert property (
    media_req_valid && !media_ack |=> media_req_valid && $stable(media_req))
    else $error("media request dropped early");
  busy_read_a: assert property (
    st_rd && media_req_valid |=> prdata[BIT_BUSY])
    else $error("busy clear while working");
  track_base_a: assert property (
    $rose(media_req_valid) && media_req.write_zero
    |-> media_req.lba % SECTORS_PER_TRACK == 28'h0)
    else $error("format address not track base");
  one_kind_a: assert property (
    media_req_valid |-> $onehot0({media_req.write_zero, media_req.flush, media_req.diag}))
    else $error("mixed media request");
  cover property (media_req.flush && media_ack && cache_dirty);
  cover property (media_req.write_zero && media_ack);
  cover property (st_rd && media_req_valid);
endmodule // hk_cmd_chk
bind hk_cmd_exec hk_cmd_chk chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .media_req(media_req),
  .media_req_valid(media_req_valid),
  .media_ack(media_ack),
  .cache_dirty(cache_dirty)
);
`default_nettype wire

// ===== bench/media_model.sv
// Behavioural model of the media and sector engine.
`timescale 1ns/1ps
`default_nettype none
module media_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire hk_cmd_pkg::media_req_type media_req,
  input wire logic media_req_valid,
  input wire logic [3:0] delay,
  input wire logic [7:0] code,
  input wire logic [3:0] dirty_load,
  input wire logic load,
  output logic media_ack,
  output logic media_sector_bad,
  output logic cache_dirty,
  output logic [7:0] diag_code,
  output logic [7:0] zero_acks,
  output logic [27:0] last_lba
);
  import hk_cmd_pkg::*;
  logic [3:0] wait_cnt;
  logic [3:0] dirty;
  assign cache_dirty = dirty != 4'h0;
  // The code is only valid with the acknowledge, so it is scrambled otherwise.
  assign diag_code = media_ack ? code : ~code;
  // One sector position per track is bad; keyed to the address so it holds for the whole request.
  assign media_sector_bad = media_req_valid && media_req.lba % SECTORS_PER_TRACK == 28'h5;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 4'h0;
      media_ack <= 1'h0;
      dirty <= 4'h0;
      zero_acks <= 8'h00;
      last_lba <= 28'h0;
    end
    else
    begin
      media_ack <= 1'h0;
      if (load)
      begin
        dirty <= dirty_load;
        zero_acks <= 8'h00;
      end
      else if (media_req_valid && !media_ack)
      begin
        if (wait_cnt < delay)
          wait_cnt <= wait_cnt + 4'h1;
        else
        begin
          wait_cnt <= 4'h0;
          media_ack <= 1'h1;
          zero_acks <= zero_acks + 8'h01;
          last_lba <= media_req.lba;
          if (media_req.flush && cache_dirty)
            dirty <= dirty - 4'h1;
        end
      end
    end
  end
endmodule // media_model
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the housekeeping command executor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hk_cmd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, media_req_valid, media_ack, media_sector_bad, cache_dirty;
  logic spindle_at_speed = 0, standby_mode = 0, sleep_mode = 0;
  logic [27:0] max_lba = 28'h0FFFFFF, last_lba;
  logic [7:0] diag_code, code = 0, zero_acks;
  logic [3:0] delay = 0, dirty_load = 0;
  media_req_type media_req;
  int miscompares = 0, check_count = 0, cycles = 0;
  always #12.5 pclk = ~pclk;
  hk_cmd_exec dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .spindle_at_speed, .standby_mode, .sleep_mode, .max_lba, .media_req,
    .media_req_valid, .media_ack, .media_sector_bad, .cache_dirty, .diag_code);
  media_model model_u (.pclk, .presetn, .media_req, .media_req_valid, .delay, .code,
    .dirty_load, .load, .media_ack, .media_sector_bad, .cache_dirty, .diag_code, .zero_acks,
    .last_lba);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'h0, ADDR_STATUS, 32'h0);
      n++;
    end
    while (rd[BIT_BUSY] !== 1'h0 && n < 500);
    check(32'(rd[BIT_BUSY]), 32'h0);
  endtask
  task automatic clear;
    @(posedge pclk);
    load <= 1'h1;
    @(posedge pclk);
    load <= 1'h0;
  endtask
  function automatic logic [7:0] pq_exp(input logic s, input logic sb, input logic sl);
    return (s && !sb && !sl) ? POWER_ACTIVE : POWER_IDLE;
  endfunction
  // Operand p packs device/head, cylinder high, cylinder low and sector number.
  task automatic fmt(input logic [31:0] p, input logic [27:0] b, input logic [7:0] n);
    logic [31:0] r;
    logic [27:0] e;
    clear();
    for (int k = 0; k < 4; k++)
      apb(1'h1, ADDR_SECTOR_NUMBER + 12'(4 * k), 32'(p[8 * k +: 8]));
    apb(1'h1, ADDR_COMMAND, 32'(CMD_FORMAT_TRACK));
    wait_idle();
    check(32'(zero_acks), 32'(n));
    apb(1'h0, ADDR_ERROR, 32'h0);
    check(32'(rd[BIT_ABORT]), 32'(n == 8'h0));
    apb(1'h0, ADDR_STATUS, 32'h0);
    check(32'(rd[BIT_ERROR]), 32'(n == 8'h0));
    e = b + 28'(SPT - 1);
    if (n != 8'h0)
      check(32'(last_lba), 32'(e));
    if (n != 8'h0 && p[30])
    begin
      r = 32'h0;
      for (int k = 0; k < 3; k++)
      begin
        apb(1'h0, ADDR_SECTOR_NUMBER + 12'(4 * k), 32'h0);
        r[8 * k +: 8] = rd[7:0];
      end
      check(r, {8'h0, e[23:0]});
    end
  endtask
  initial
  begin
    logic [27:0] l;
    void'($urandom(32'h628FF3BF));
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 16; i++)
    begin
      {spindle_at_speed, standby_mode, sleep_mode} <= 3'(i >> 1);
      apb(1'h1, ADDR_COMMAND, 32'(i[0] ? CMD_POWER_QUERY_ALT : CMD_POWER_QUERY));
      wait_idle();
      apb(1'h0, ADDR_SECTOR_COUNT, 32'h0);
      check(rd, 32'(pq_exp(i[3], i[2], i[1])));
    end
    $display("power query test done");
    apb(1'h1, ADDR_CONTROL, 32'h1);
    apb(1'h1, ADDR_COMMAND, 32'(CMD_POWER_QUERY));
    apb(1'h0, ADDR_COMMAND, 32'h0);
    check(rd, 32'(CMD_POWER_QUERY_ALT));
    apb(1'h1, ADDR_CONTROL, 32'h0);
    $display("device select test done");
    code <= 8'($urandom);
    delay <= 4'($urandom % 4);
    apb(1'h1, ADDR_COMMAND, 32'(CMD_DIAGNOSE));
    wait_idle();
    apb(1'h0, ADDR_ERROR, 32'h0);
    check(rd, 32'(code));
    $display("diagnostic test done");
    dirty_load <= 4'h3;
    clear();
    apb(1'h1, ADDR_COMMAND, 32'(CMD_FLUSH));
    apb(1'h0, ADDR_STATUS, 32'h0);
    check(32'(rd[BIT_BUSY]), 32'h1);
    wait_idle();
    check(32'(cache_dirty), 32'h0);
    check(32'(zero_acks), 32'(dirty_load));
    $display("flush test done");
    for (int i = 0; i < 3; i++)
    begin
      l = (i == 0) ? max_lba : 28'($urandom % max_lba);
      fmt({4'hE, l}, l - l % 28'h3F, 8'h3F);
    end
    l = 28'($urandom);
    fmt({4'hA, l[3:0], 4'h0, l[15:4], 8'h01}, 28'(l[15:0]) * 28'h3F, 8'h3F);
    fmt({4'hE, max_lba + 28'h1}, 28'h0, 8'h0);
    $display("format test done");
    apb(1'h1, ADDR_COMMAND, 32'h0000003C);
    wait_idle();
    apb(1'h0, ADDR_ERROR, 32'h0);
    check(32'(rd[BIT_ABORT]), 32'h1);
    apb(1'h0, 12'h0FC, 32'h0);
    check(32'(err), 32'h1);
    $display("unmapped test done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
